// ---- cdsc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

module cdsc_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins from the host and the analog core, asynchronous
  input wire logic clear_pin,
  input wire logic latch_n_pin,
  input wire logic headroom_low,
  input wire logic over_temp,
  // data register write from the serial logic, one-cycle strobe
  input wire logic data_write,
  input wire logic [15:0] data_word,
  // control register write from the serial logic, one-cycle strobe
  input wire logic ctrl_write,
  input wire logic ramp_enable_bit,
  input wire logic [3:0] ramp_update_rate_code,
  input wire logic [2:0] ramp_increment_code,
  input wire logic external_resistor_select,
  // dac code and resistor choice to the analog core
  output logic [15:0] dac_code,
  output logic current_set_resistor_ext,
  // shared open-drain alarm pin
  output logic fault_pin_out,
  output logic fault_pin_oe,
  // status flags
  output logic iout_fault_flag,
  output logic overtemp_flag,
  output logic slew_active_flag
);

  // three-stage synchronisers and filtered levels
  logic [3:0] sync1_reg, sync2_reg, sync3_reg, lvl_reg, lvl_prev_reg;
  logic [3:0] lvl_next;

  // control register fields
  logic ramp_en_reg, ramp_en_next;
  logic [3:0] rate_reg, rate_next;
  logic [2:0] inc_reg, inc_next;
  logic res_sel_reg, res_sel_next;

  // codes and ramp timer
  logic [15:0] held_reg, held_next;
  logic [15:0] target_reg, target_next;
  logic [15:0] code_reg, code_next;
  logic [11:0] cnt_reg, cnt_next;
  logic slew_reg, slew_next;
  logic fault_oe_reg, fault_oe_next;
  logic iout_flag_reg, iout_flag_next;
  logic temp_flag_reg, temp_flag_next;

  // decoded events
  logic clear_lvl, restore, ramping, tick;

  // one step toward the target, never past it
  function automatic logic [15:0] step_toward(input logic [15:0] cur,
                                              input logic [15:0] tgt,
                                              input logic [15:0] inc);
    logic [15:0] gap;
    gap = (cur < tgt) ? (tgt - cur) : (cur - tgt);
    if (gap <= inc) begin
      step_toward = tgt;
    end else if (cur < tgt) begin
      step_toward = cur + inc;
    end else begin
      step_toward = cur - inc;
    end
  endfunction

  // a change counts once the second and third stages agree
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : lvl_reg[i];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_reg <= cdsc_pkg::PIN_RST;
      sync2_reg <= cdsc_pkg::PIN_RST;
      sync3_reg <= cdsc_pkg::PIN_RST;
      lvl_reg <= cdsc_pkg::PIN_RST;
      lvl_prev_reg <= cdsc_pkg::PIN_RST;
    end else begin
      sync1_reg <= {over_temp, headroom_low, latch_n_pin, clear_pin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg <= lvl_next;
      lvl_prev_reg <= lvl_reg;
    end
  end

  // event decode
  assign clear_lvl = lvl_reg[cdsc_pkg::PIN_CLEAR];
  assign restore = lvl_reg[cdsc_pkg::PIN_LATCH_N] & ~lvl_prev_reg[cdsc_pkg::PIN_LATCH_N]
                   & ~clear_lvl & ~data_write;
  assign ramping = ramp_en_reg & (code_reg != target_reg);
  assign tick = ramping & (cnt_reg == 12'h000);

  // control register and target selection
  always_comb begin
    ramp_en_next = ramp_en_reg;
    rate_next = rate_reg;
    inc_next = inc_reg;
    res_sel_next = res_sel_reg;
    held_next = held_reg;
    target_next = target_reg;
    if (ctrl_write) begin
      ramp_en_next = ramp_enable_bit;
      rate_next = ramp_update_rate_code;
      inc_next = ramp_increment_code;
      res_sel_next = external_resistor_select;
    end
    if (data_write && !clear_lvl) begin
      held_next = data_word;
    end
    if (clear_lvl) begin
      target_next = cdsc_pkg::ZERO_SCALE_CODE;
    end else if (ctrl_write && ramping) begin
      target_next = code_reg;
    end else if (restore) begin
      target_next = held_reg;
    end else if (data_write) begin
      target_next = data_word;
    end
    // target otherwise holds after clear falls
  end

  // output code, ramp timer and status
  always_comb begin
    code_next = code_reg;
    cnt_next = cnt_reg;
    if (!ramp_en_reg) begin
      code_next = target_reg;
    // a control write on an update tick freezes the code instead of stepping it
    end else if (tick && !ctrl_write) begin
      code_next = step_toward(code_reg, target_reg, cdsc_pkg::step_size(inc_reg));
    end
    if (!ramping || tick) begin
      cnt_next = cdsc_pkg::rate_cycles(rate_reg) - 12'h001;
    end else begin
      cnt_next = cnt_reg - 12'h001;
    end
    slew_next = ramping;
    iout_flag_next = lvl_reg[cdsc_pkg::PIN_HEADROOM];
    temp_flag_next = lvl_reg[cdsc_pkg::PIN_OVERTEMP];
    fault_oe_next = lvl_reg[cdsc_pkg::PIN_HEADROOM] | lvl_reg[cdsc_pkg::PIN_OVERTEMP];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ramp_en_reg <= cdsc_pkg::RAMP_EN_RST;
      rate_reg <= cdsc_pkg::RATE_RST;
      inc_reg <= cdsc_pkg::INC_RST;
      res_sel_reg <= cdsc_pkg::RES_SEL_RST;
      held_reg <= cdsc_pkg::ZERO_SCALE_CODE;
      target_reg <= cdsc_pkg::ZERO_SCALE_CODE;
      code_reg <= cdsc_pkg::ZERO_SCALE_CODE;
      cnt_reg <= 12'h000;
      slew_reg <= 1'b0;
      iout_flag_reg <= 1'b0;
      temp_flag_reg <= 1'b0;
      fault_oe_reg <= 1'b0;
    end else begin
      ramp_en_reg <= ramp_en_next;
      rate_reg <= rate_next;
      inc_reg <= inc_next;
      res_sel_reg <= res_sel_next;
      held_reg <= held_next;
      target_reg <= target_next;
      code_reg <= code_next;
      cnt_reg <= cnt_next;
      slew_reg <= slew_next;
      iout_flag_reg <= iout_flag_next;
      temp_flag_reg <= temp_flag_next;
      fault_oe_reg <= fault_oe_next;
    end
  end

  // outputs straight from flip-flops; the pin only ever pulls low
  logic fault_out_reg;
  always_ff @(posedge clk) begin
    fault_out_reg <= 1'b0;
  end

  assign dac_code = code_reg;
  assign current_set_resistor_ext = res_sel_reg;
  assign fault_pin_out = fault_out_reg;
  assign fault_pin_oe = fault_oe_reg;
  assign iout_fault_flag = iout_flag_reg;
  assign overtemp_flag = temp_flag_reg;
  assign slew_active_flag = slew_reg;

  // checks
  a_fault_any_source: assert property (@(posedge clk) disable iff (sys_rst)
    (lvl_reg[2] || lvl_reg[3]) |=> fault_pin_oe)
    else $error("alarm pin not driven while a fault is present");

  a_alarm_release: assert property (@(posedge clk) disable iff (sys_rst)
    !(lvl_reg[cdsc_pkg::PIN_HEADROOM] || lvl_reg[cdsc_pkg::PIN_OVERTEMP]) |=> !fault_pin_oe)
    else $error("alarm pin held with no fault present");

  a_headroom_flag_follow: assert property (@(posedge clk) disable iff (sys_rst)
    lvl_reg[2] |=> iout_fault_flag && fault_pin_oe)
    else $error("headroom fault not flagged");

  a_overtemp_flag_follow: assert property (@(posedge clk) disable iff (sys_rst)
    lvl_reg[3] |=> overtemp_flag && fault_pin_oe)
    else $error("overtemp not flagged");

  a_flags_separate: assert property (@(posedge clk) disable iff (sys_rst)
    (lvl_reg[2] && !lvl_reg[3]) |=> !overtemp_flag && iout_fault_flag)
    else $error("fault flags mixed up");

  a_clear_forces_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (clear_lvl && !ramp_en_reg) ##1 (clear_lvl && !ramp_en_reg) |=> dac_code == 16'h0000)
    else $error("clear did not force zero-scale");

  a_clear_holds_value: assert property (@(posedge clk) disable iff (sys_rst)
    (!clear_lvl && $past(clear_lvl) && !restore && !data_write && !ctrl_write)
      |=> target_reg == 16'h0000)
    else $error("output left cleared value on its own");

  a_latch_restores: assert property (@(posedge clk) disable iff (sys_rst)
    (restore && !(ctrl_write && ramping)) |=> target_reg == $past(held_reg))
    else $error("latch pulse did not restore held code");

  a_no_write_in_clear: assert property (@(posedge clk) disable iff (sys_rst)
    clear_lvl |=> $stable(held_reg) && target_reg == 16'h0000)
    else $error("value accepted while clear high");

  a_resistor_select: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_write |=> current_set_resistor_ext == $past(external_resistor_select))
    else $error("resistor select not taken");

  a_direct_update: assert property (@(posedge clk) disable iff (sys_rst)
    !ramp_en_reg |=> dac_code == $past(target_reg))
    else $error("code not applied in one step");

  a_steps_only_on_tick: assert property (@(posedge clk) disable iff (sys_rst)
    (ramp_en_reg && !tick) |=> $stable(dac_code))
    else $error("ramp moved without an update tick");

  a_tick_interval: assert property (@(posedge clk) disable iff (sys_rst)
    (tick && !ctrl_write) |=> cnt_reg == cdsc_pkg::rate_cycles(rate_reg) - 12'h001)
    else $error("update interval not reloaded from rate code");

  a_rate_fastest: assert property (@(posedge clk) disable iff (sys_rst)
    (tick && rate_reg == 4'h0) |=> cnt_reg == 12'h025)
    else $error("rate code 0 decode wrong");

  a_slew_flag_state: assert property (@(posedge clk) disable iff (sys_rst)
    ramping |=> slew_active_flag)
    else $error("slewing flag missing during ramp");

  a_clear_ramps_down: assert property (@(posedge clk) disable iff (sys_rst)
    (clear_lvl && ramp_en_reg && dac_code > 16'h0001 && !tick) |=> dac_code != 16'h0000)
    else $error("clear jumped instead of ramping");

  a_clear_step_down: assert property (@(posedge clk) disable iff (sys_rst)
    (clear_lvl && tick && !ctrl_write && target_reg == cdsc_pkg::ZERO_SCALE_CODE
      && code_reg > cdsc_pkg::step_size(inc_reg))
      |=> dac_code == $past(code_reg) - cdsc_pkg::step_size($past(inc_reg)))
    else $error("clear ramp step size wrong");

  a_freeze_on_ctrl: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_write && ramping && !clear_lvl) |=> target_reg == $past(code_reg))
    else $error("control write did not freeze the ramp");

  a_no_overshoot: assert property (@(posedge clk) disable iff (sys_rst)
    (tick && !ctrl_write && code_reg < target_reg) |=> dac_code <= $past(target_reg)
      && dac_code > $past(code_reg))
    else $error("ramp step overshot the target");

  c_ramp_done: cover property (@(posedge clk) disable iff (sys_rst)
    slew_active_flag ##1 !slew_active_flag);
  c_clear_restore: cover property (@(posedge clk) disable iff (sys_rst)
    $fell(clear_lvl) ##[1:50] restore);
  c_freeze: cover property (@(posedge clk) disable iff (sys_rst)
    ctrl_write && ramping);
  c_both_faults: cover property (@(posedge clk) disable iff (sys_rst)
    iout_fault_flag && overtemp_flag);
  c_clear_slew: cover property (@(posedge clk) disable iff (sys_rst)
    clear_lvl && tick);

endmodule // cdsc_ctrl
`default_nettype wire

// ---- cdsc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdsc_host (
  // clock
  input wire logic clk,
  // status seen by the host
  input wire logic slew_active_flag,
  // pins and strobes toward the device
  output logic clear_pin,
  output logic latch_n_pin,
  output logic data_write,
  output logic [15:0] data_word,
  output logic ctrl_write,
  output logic ramp_enable_bit,
  output logic [3:0] ramp_update_rate_code,
  output logic [2:0] ramp_increment_code,
  output logic external_resistor_select
);
  // idle levels from time zero
  initial begin
    {clear_pin, latch_n_pin, data_write, ctrl_write} = 4'h4;
    data_word = 16'h0000;
    {ramp_enable_bit, ramp_update_rate_code, ramp_increment_code} = 8'h00;
    external_resistor_select = 1'b0;
  end

  // one-cycle data strobe; the word is inverted after so nothing can use a stale copy
  task automatic write_data(input logic [15:0] w);
    @(negedge clk);
    data_word = w;
    data_write = 1'b1;
    @(negedge clk);
    data_write = 1'b0;
    data_word = ~w;
  endtask

  // control strobe; waits for a running ramp unless halting it on purpose
  task automatic write_ctrl(input logic [8:0] f, input bit halt);
    int n;
    n = 0;
    while (!halt && slew_active_flag !== 1'b0 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    {ramp_enable_bit, ramp_update_rate_code, ramp_increment_code, external_resistor_select} = f;
    ctrl_write = 1'b1;
    @(negedge clk);
    ctrl_write = 1'b0;
    {ramp_enable_bit, ramp_update_rate_code, ramp_increment_code, external_resistor_select} = ~f;
  endtask

  // clear level; callers may also send data while it is high
  task automatic set_clear(input logic v);
    @(negedge clk);
    clear_pin = v;
  endtask

  // latch low pulse with no data clocked in
  task automatic pulse_latch(input int n);
    @(negedge clk);
    latch_n_pin = 1'b0;
    repeat (n) @(negedge clk);
    latch_n_pin = 1'b1;
  endtask
endmodule // cdsc_host
`default_nettype wire

// ---- cdsc_pkg.sv ----
`default_nettype none
package cdsc_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ = 10_000_000;

  // dac code width and zero-scale code of every range
  localparam int unsigned CODE_W = 16;
  localparam logic [15:0] ZERO_SCALE_CODE = 16'h0000;

  // control field widths
  localparam int unsigned RATE_W = 4;
  localparam int unsigned INC_W = 3;

  // reset values of the control fields
  localparam logic RAMP_EN_RST = 1'h0;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [2:0] INC_RST = 3'h0;
  localparam logic RES_SEL_RST = 1'h0;

  // index of each synchronised pin inside the sync vectors
  localparam int unsigned PIN_CLEAR = 0;
  localparam int unsigned PIN_LATCH_N = 1;
  localparam int unsigned PIN_HEADROOM = 2;
  localparam int unsigned PIN_OVERTEMP = 3;
  localparam logic [3:0] PIN_RST = 4'h2;

  // update frequencies in hz, one per rate code
  localparam int unsigned RATE_HZ [16] = '{
    257730, 198410, 152440, 131580, 115740, 69440, 37590, 25770,
    20160, 16030, 10290, 8280, 6900, 5530, 4240, 3300
  };

  // width of the update interval counter
  localparam int unsigned TICK_W = 12;

  // clock cycles between two ramp updates for a rate code
  function automatic logic [11:0] rate_cycles(input logic [3:0] code);
    int unsigned cyc;
    cyc = CLK_HZ / RATE_HZ[code];
    rate_cycles = cyc[11:0];
  endfunction

  // code increment per update: two to the power of the step code
  function automatic logic [15:0] step_size(input logic [2:0] code);
    step_size = 16'h0001 << code;
  endfunction

endpackage
`default_nettype wire

// ---- tb_current_dac_slew_clear_fault_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_current_dac_slew_clear_fault_ctrl;
  logic clk, sys_rst, headroom_low, over_temp, clear_pin, latch_n_pin, data_write, ctrl_write;
  logic ramp_enable_bit, external_resistor_select, current_set_resistor_ext, fault_pin_out;
  logic fault_pin_oe, iout_fault_flag, overtemp_flag, slew_active_flag;
  logic [15:0] data_word, dac_code, v;
  logic [3:0] ramp_update_rate_code;
  logic [2:0] ramp_increment_code;
  int errors, tests_run;
  // cycles between updates: clock rate over update frequency, rounded down
  int gap_tab [16] = '{38, 50, 65, 75, 86, 144, 266, 388, 496, 623, 971, 1207, 1449, 1808,
    2358, 3030};

  cdsc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .clear_pin(clear_pin),
    .latch_n_pin(latch_n_pin), .headroom_low(headroom_low), .over_temp(over_temp),
    .data_write(data_write), .data_word(data_word), .ctrl_write(ctrl_write),
    .ramp_enable_bit(ramp_enable_bit), .ramp_update_rate_code(ramp_update_rate_code),
    .ramp_increment_code(ramp_increment_code),
    .external_resistor_select(external_resistor_select), .dac_code(dac_code),
    .current_set_resistor_ext(current_set_resistor_ext), .fault_pin_out(fault_pin_out),
    .fault_pin_oe(fault_pin_oe), .iout_fault_flag(iout_fault_flag),
    .overtemp_flag(overtemp_flag), .slew_active_flag(slew_active_flag));

  cdsc_host host (.clk(clk), .slew_active_flag(slew_active_flag), .clear_pin(clear_pin),
    .latch_n_pin(latch_n_pin), .data_write(data_write), .data_word(data_word),
    .ctrl_write(ctrl_write), .ramp_enable_bit(ramp_enable_bit),
    .ramp_update_rate_code(ramp_update_rate_code), .ramp_increment_code(ramp_increment_code),
    .external_resistor_select(external_resistor_select));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ramp up by just under three steps and time every update after the first
  task automatic ramp(input logic [3:0] r, input logic [2:0] k);
    logic [15:0] step, tgt, last;
    int ch, lc;
    step = 16'h0001 << k;
    host.write_ctrl({1'b1, r, k, 1'b0}, 0);
    last = dac_code;
    tgt = 16'(last + 3 * step - 1);
    ch = 0;
    lc = 0;
    host.write_data(tgt);
    for (int n = 0; n < 4 * gap_tab[r] + 100; n++) begin
      @(negedge clk);
      if (dac_code !== last) begin
        ch++;
        check(dac_code - last <= step && dac_code <= tgt, 1);
        if (ch == 1) check(slew_active_flag, 1);
        if (ch > 1) check(n - lc, gap_tab[r]);
        last = dac_code;
        lc = n;
      end
      if (n > 4 && slew_active_flag === 1'b0) break;
    end
    check(dac_code, tgt);
    check(ch, (k == 0) ? 2 : 3);
    check(slew_active_flag, 0);
  endtask

  // hang guard, well beyond the full sequence
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    {headroom_low, over_temp} = 2'h0;
    errors = 0;
    tests_run = 0;
    cyc(2);
    sys_rst = 1'b0;
    cyc(6);
    // every fault combination on pin and flags
    for (int f = 0; f < 4; f++) begin
      {headroom_low, over_temp} = f[1:0];
      cyc(8);
      check(fault_pin_oe, f != 0);
      check(fault_pin_out, 0);
      check({iout_fault_flag, overtemp_flag}, f[1:0]);
    end
    {headroom_low, over_temp} = 2'h0;
    // direct update and resistor choice
    host.write_ctrl(9'h001, 0);
    host.write_data(16'h1234);
    cyc(2);
    check(dac_code, 16'h1234);
    check(current_set_resistor_ext, 1);
    host.write_ctrl(9'h000, 0);
    cyc(2);
    check(current_set_resistor_ext, 0);
    // clear, refused write, hold, restore
    host.set_clear(1'b1);
    cyc(8);
    check(dac_code, 16'h0000);
    host.write_data(16'h5555);
    cyc(4);
    check(dac_code, 16'h0000);
    host.set_clear(1'b0);
    cyc(8);
    check(dac_code, 16'h0000);
    host.pulse_latch(6);
    cyc(10);
    check(dac_code, 16'h1234);
    // every rate code, every step code twice
    for (int r = 0; r < 16; r++) ramp(r[3:0], r[2:0]);
    // halt a ramp with a control write
    host.write_ctrl(9'h100, 0);
    host.write_data(dac_code + 16'h03e8);
    cyc(200);
    host.write_ctrl(9'h100, 1);
    cyc(4);
    v = dac_code;
    cyc(100);
    check(dac_code, v);
    check(slew_active_flag, 0);
    // clear while ramping slews down
    host.write_ctrl(9'h10e, 0);
    host.set_clear(1'b1);
    cyc(10);
    check(slew_active_flag, 1);
    check(dac_code == 16'h0000, 0);
    for (int n = 0; n < 4000 && dac_code !== 16'h0000; n++) @(negedge clk);
    check(dac_code, 16'h0000);
    host.set_clear(1'b0);
    summarize();
  end
endmodule // tb_current_dac_slew_clear_fault_ctrl
`default_nettype wire
